/* hdl/secl_defs.vh */
// constants for the serial eeprom configuration loader
`ifndef SECL_DEFS_VH
`define SECL_DEFS_VH

// system clock period
`define SECL_CLK_NS 8
// serial clock cycle times
`define SECL_SK_FAST_NS 800
`define SECL_SK_SLOW_NS 4000
// half cycles in system clocks
`define SECL_HALF_FAST (`SECL_SK_FAST_NS / `SECL_CLK_NS / 2)
`define SECL_HALF_SLOW (`SECL_SK_SLOW_NS / `SECL_CLK_NS / 2)

// bus speed field codes
`define SECL_SPEED_125 2'b00
`define SECL_SPEED_25 2'b11

// read frame: start bit, opcode, address, then data
`define SECL_READ_OP 2'b10
`define SECL_ADDR_W 6
`define SECL_DATA_W 16
`define SECL_CMD_BITS 9
`define SECL_FRAME_BITS 25
`define SECL_DATA_FIRST 9
// number of configuration words loaded
`define SECL_WORD_COUNT 6'h08
// last count of strap settling after reset; settling lasts 5 system clocks
`define SECL_SETTLE 4'h4

`endif

/* hdl/secl_loader.v */
// serial eeprom configuration loader run once after reset
`timescale 1ns/1ps
// What this block does
// R1: strap high: eeprom present, load from it
// R2: strap low: no eeprom access, skip load
// R3: drive read command out on serial out
// R4: speed code 11: serial clock cycle 4 us
// R5: speed code 00: serial clock cycle 800 ns
// R6: sample eeprom data on serial in pin
// R7: no eeprom: serial in straps 8/16 bit bus
// R8: one read pass after reset, standard sequence
`include "secl_defs.vh"

module secl_loader (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  // strap and speed setting
  input wire romPresentStrap,
  input wire [1:0] internalBusSpeedCtrl,
  // eeprom pins
  output reg romChipSelect,
  output reg romSerialClock,
  output reg romSerialOut,
  input wire romSerialIn,
  // configuration words out
  output reg [`SECL_ADDR_W-1:0] cfgAddr,
  output reg [`SECL_DATA_W-1:0] cfgData,
  output reg cfgValid,
  // status
  output reg hostBus16,
  output reg romUsed,
  output reg loadDone
);

  localparam [2:0] ST_SETTLE = 3'h0;
  localparam [2:0] ST_DECIDE = 3'h1;
  localparam [2:0] ST_SHIFT = 3'h2;
  localparam [2:0] ST_GAP = 3'h3;
  localparam [2:0] ST_DONE = 3'h4;

  // half cycle lengths and frame ends, cut to their counter widths
  localparam integer HALF_FAST_I = `SECL_HALF_FAST;
  localparam integer HALF_SLOW_I = `SECL_HALF_SLOW;
  localparam integer FRAME_LAST_I = `SECL_FRAME_BITS - 1;
  localparam [9:0] HALF_FAST = HALF_FAST_I[9:0];
  localparam [9:0] HALF_SLOW = HALF_SLOW_I[9:0];
  localparam [4:0] FRAME_LAST = FRAME_LAST_I[4:0];
  localparam [5:0] WORD_LAST = `SECL_WORD_COUNT - 6'h01;

  // half serial clock length from speed code
  function [9:0] halfLen;
    input [1:0] speed;
    begin
      if (speed == `SECL_SPEED_125) begin
        halfLen = HALF_FAST; // see R5
      end else begin
        halfLen = HALF_SLOW; // see R4
      end
    end
  endfunction

  // command bit for frame position idx
  function cmdBit;
    input [`SECL_ADDR_W-1:0] addr;
    input [4:0] idx;
    reg [`SECL_CMD_BITS-1:0] cmd;
    begin
      cmd = {1'b1, `SECL_READ_OP, addr};
      if (idx < `SECL_CMD_BITS) begin
        cmdBit = cmd[`SECL_CMD_BITS-1-idx];
      end else begin
        cmdBit = 1'b0;
      end
    end
  endfunction

  // data word with one more bit shifted in at the bottom
  function [`SECL_DATA_W-1:0] shiftIn;
    input [`SECL_DATA_W-1:0] word;
    input bitIn;
    begin
      shiftIn = {word[`SECL_DATA_W-2:0], bitIn};
    end
  endfunction

  // next half cycle count
  function [9:0] halfStep;
    input [9:0] cnt;
    begin
      halfStep = cnt + 10'h001;
    end
  endfunction

  reg strapMeta_q, strapSync_q;
  reg dinMeta_q, dinSync_q;
  reg [2:0] state_q;
  reg [3:0] settle_q;
  reg [9:0] halfCnt_q;
  reg [4:0] bitIdx_q;
  reg [`SECL_ADDR_W-1:0] addr_q;
  reg [`SECL_DATA_W-1:0] shift_q;

  // at or past the end, so a live speed change cannot skip the end
  wire halfEnd = (halfCnt_q >= halfLen(internalBusSpeedCtrl) - 10'd1);
  wire lastBit = (bitIdx_q == FRAME_LAST);
  wire lastWord = (addr_q == WORD_LAST);
  wire [4:0] nextIdx = bitIdx_q + 5'h01;
  wire [`SECL_ADDR_W-1:0] nextAddr = addr_q + 6'h01;

  // pin synchronisers
  always @(posedge sys_clk) begin
    if (!rstn) begin
      strapMeta_q <= 1'b0;
      strapSync_q <= 1'b0;
      dinMeta_q <= 1'b0;
      dinSync_q <= 1'b0;
    end else begin
      strapMeta_q <= romPresentStrap;
      strapSync_q <= strapMeta_q;
      dinMeta_q <= romSerialIn;
      dinSync_q <= dinMeta_q;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= ST_SETTLE;
      settle_q <= 4'h0;
      halfCnt_q <= 10'h000;
      bitIdx_q <= 5'h00;
      addr_q <= {`SECL_ADDR_W{1'b0}};
      shift_q <= {`SECL_DATA_W{1'b0}};
      romChipSelect <= 1'b0;
      romSerialClock <= 1'b0;
      romSerialOut <= 1'b0;
      cfgAddr <= {`SECL_ADDR_W{1'b0}};
      cfgData <= {`SECL_DATA_W{1'b0}};
      cfgValid <= 1'b0;
      hostBus16 <= 1'b0;
      romUsed <= 1'b0;
      loadDone <= 1'b0;
    end else begin
      cfgValid <= 1'b0;
      case (state_q)
        ST_SETTLE: begin
          // let the synchronised straps settle
          settle_q <= settle_q + 4'h1;
          if (settle_q == `SECL_SETTLE) begin
            state_q <= ST_DECIDE;
          end
        end
        ST_DECIDE: begin
          // straps are read once per reset
          if (strapSync_q) begin
            romUsed <= 1'b1; // see R1
            romChipSelect <= 1'b1; // see R8
            romSerialOut <= cmdBit(addr_q, 5'h00); // see R3
            halfCnt_q <= 10'h000;
            bitIdx_q <= 5'h00;
            state_q <= ST_SHIFT;
          end else begin
            hostBus16 <= dinSync_q; // see R7
            loadDone <= 1'b1; // see R2
            state_q <= ST_DONE;
          end
        end
        ST_SHIFT: begin
          if (halfEnd) begin
            halfCnt_q <= 10'h000;
            if (!romSerialClock) begin
              romSerialClock <= 1'b1;
            end else begin
              romSerialClock <= 1'b0;
              // sample just before the falling edge
              if (bitIdx_q >= `SECL_DATA_FIRST) begin
                shift_q <= shiftIn(shift_q, dinSync_q); // see R6
              end
              if (lastBit) begin
                cfgAddr <= addr_q;
                cfgData <= shiftIn(shift_q, dinSync_q);
                cfgValid <= 1'b1;
                romChipSelect <= 1'b0;
                romSerialOut <= 1'b0;
                state_q <= ST_GAP;
              end else begin
                bitIdx_q <= nextIdx;
                romSerialOut <= cmdBit(addr_q, nextIdx); // see R3
              end
            end
          end else begin
            halfCnt_q <= halfStep(halfCnt_q);
          end
        end
        ST_GAP: begin
          // chip select low for one half cycle between words
          if (halfEnd) begin
            halfCnt_q <= 10'h000;
            if (lastWord) begin
              loadDone <= 1'b1; // see R8
              state_q <= ST_DONE;
            end else begin
              addr_q <= nextAddr;
              bitIdx_q <= 5'h00;
              romChipSelect <= 1'b1;
              romSerialOut <= cmdBit(nextAddr, 5'h00);
              state_q <= ST_SHIFT;
            end
          end else begin
            halfCnt_q <= halfStep(halfCnt_q);
          end
        end
        ST_DONE: begin
          state_q <= ST_DONE;
        end
        default: begin
          state_q <= ST_DONE;
        end
      endcase
    end
  end

endmodule

/* testbench/secl_loader_chk.sv */
// assertions on the loader pins
`timescale 1ns/1ps
module secl_loader_chk (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  // watched pins
  input wire [1:0] internalBusSpeedCtrl,
  input wire romChipSelect,
  input wire romSerialClock,
  input wire romSerialOut,
  input wire cfgValid,
  input wire hostBus16,
  input wire romUsed,
  input wire loadDone
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  AST_SKIP:
    assert property (loadDone && !romUsed |-> !romChipSelect && !romSerialClock) else $error("rom touched");
  AST_START:
    assert property ($rose(romChipSelect) |-> romSerialOut && !romSerialClock) else $error("bad start");
  AST_FAST:
    assert property ($rose(romSerialClock) && internalBusSpeedCtrl == 2'b00 |-> ##49 romSerialClock ##1
      !romSerialClock) else $error("fast half");
  AST_SLOW:
    assert property ($rose(romSerialClock) && internalBusSpeedCtrl == 2'b11 |-> ##249 romSerialClock ##1
      !romSerialClock) else $error("slow half");
  AST_GATE:
    assert property (romSerialClock |-> romChipSelect) else $error("clock outside frame");
  AST_VALID:
    assert property (cfgValid |-> $fell(romChipSelect)) else $error("word not at frame end");
  AST_BUS:
    assert property (romUsed |-> !hostBus16) else $error("bus strap with rom");
  AST_HOLD:
    assert property (loadDone |=> loadDone && !romChipSelect) else $error("second pass");
  cover property (cfgValid);
  cover property (loadDone && !romUsed);
  cover property ($rose(romSerialClock) && internalBusSpeedCtrl == 2'b11);
endmodule
bind secl_loader secl_loader_chk u_chk (.sys_clk(sys_clk), .rstn(rstn), .internalBusSpeedCtrl(internalBusSpeedCtrl),
  .romChipSelect(romChipSelect), .romSerialClock(romSerialClock), .romSerialOut(romSerialOut),
  .cfgValid(cfgValid), .hostBus16(hostBus16), .romUsed(romUsed), .loadDone(loadDone));

/* testbench/secl_rom_model.sv */
// serial eeprom model answering read frames
`timescale 1ns/1ps
module secl_rom_model (
  // eeprom pins
  input wire cs,
  input wire sk,
  input wire di,
  output reg dout
);
  integer n = 0;
  reg [5:0] a = 6'h00;
  wire [15:0] w = {4'ha, a, ~a};
  initial dout = 1'b0;
  // released pin falls to its pull-down level
  always @(negedge cs) dout <= 1'b0;
  always @(posedge cs) n = 0;
  always @(posedge sk) begin
    if (n < 9) a = {a[4:0], di};
    if (n == 8) dout <= 1'b0;
    if (n > 8) dout <= w[24-n];
    n = n + 1;
  end
endmodule

/* testbench/secl_loader_bench.sv */
// bench for the configuration loader
`timescale 1ns/1ps
module secl_loader_bench;
  reg sys_clk = 1'b0;
  reg rstn = 1'b0;
  reg strap = 1'b0;
  reg busW = 1'b0;
  reg [1:0] spd = 2'b00;
  wire cs, sk, so, mdo, valid, bus16, used, done;
  wire [5:0] addr;
  wire [15:0] data;
  wire si = strap ? mdo : busW;
  integer n_mismatch = 0;
  integer check_count = 0;
  integer k;
  always #4 sys_clk = ~sys_clk;
  secl_loader u_dut (.sys_clk(sys_clk), .rstn(rstn), .romPresentStrap(strap), .internalBusSpeedCtrl(spd),
    .romChipSelect(cs), .romSerialClock(sk), .romSerialOut(so), .romSerialIn(si), .cfgAddr(addr),
    .cfgData(data), .cfgValid(valid), .hostBus16(bus16), .romUsed(used), .loadDone(done));
  secl_rom_model u_rom (.cs(cs), .sk(sk), .di(so), .dout(mdo));
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  // waits for a word pulse or for the end of loading
  task till(input bit v);
    begin
      for (k = 0; k < 14000; k = k + 1) begin
        // outputs looked at between edges, where they are settled
        @(negedge sys_clk);
        if ((v ? valid : done) === 1'b1) break;
      end
      if (k == 14000) begin
        n_mismatch = n_mismatch + 1;
        print_verdict;
      end
    end
  endtask
  task rst(input bit st, input bit bw, input [1:0] sp);
    begin
      @(posedge sys_clk);
      rstn <= 1'b0;
      strap <= st;
      busW <= bw;
      spd <= sp;
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
    end
  endtask
  task t_skip(input bit bw);
    begin
      rst(1'b0, bw, 2'b11);
      till(1'b0);
      chk("bus16", {15'h0000, bw}, {15'h0000, bus16});
      chk("used", 16'h0000, {15'h0000, used});
      $display("test skip done");
    end
  endtask
  task t_load(input [1:0] sp, input integer nw);
    integer i;
    begin
      rst(1'b1, 1'b1, sp);
      for (i = 0; i < nw; i = i + 1) begin
        till(1'b1);
        chk("addr", i[15:0], {10'h000, addr});
        chk("data", {4'ha, i[5:0], ~i[5:0]}, data);
      end
      if (nw == 8) begin
        till(1'b0);
        chk("bus16", 16'h0000, {15'h0000, bus16});
        chk("used", 16'h0001, {15'h0000, used});
      end
      $display("test load done");
    end
  endtask
  initial begin
    t_skip(1'b0);
    t_skip(1'b1);
    t_load(2'b00, 8);
    t_load(2'b11, 2);
    print_verdict;
  end
endmodule
